// [verilog/dfs_serial_master.sv]
/*
  Dual format two-wire serial master: byte-plus-acknowledge low-speed
  format or management frame format on one open-drain clock/data pair.
  Assumes pull-ups on both lines, the load strobe and idle flag come from
  the PROM port on this clock, and the user holds a request until taken.
*/
`timescale 1ns/10ps
`include "dfs_regs.svh"
module dfs_serial_master #(
  parameter int unsigned LS_QTR_CYC = `DFS_LS_QTR_CYC,
  parameter int unsigned HS_QTR_CYC = (`DFS_HS_QTR_CYC < `DFS_MIN_QTR_CYC) ?
    `DFS_MIN_QTR_CYC : `DFS_HS_QTR_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic prom_load_strobe,
  input wire logic prom_idle,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dfs_pkg::dfs_cmd_t cmd,
  output logic rsp_valid,
  output dfs_pkg::dfs_rsp_t rsp,
  output logic bus_held,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe_n,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n
);
  // Quarter counts must fit the 6-bit counter
  if (LS_QTR_CYC < 2 || LS_QTR_CYC > 64 || HS_QTR_CYC < 2 || HS_QTR_CYC > 64) begin : g_chk
    $error("dfs_serial_master: quarter-bit counts must lie in 2..64");
  end

  dfs_pkg::dfs_state_t state, next_state; // Sequencer
  logic [1:0] phase, next_phase;          // Quarter of the current bit
  logic [5:0] qcnt, next_qcnt;            // Quarter-bit divider
  logic [63:0] tx, next_tx;               // Outgoing bits, MSB first
  logic [63:0] mask, next_mask;           // 1 = we drive, 0 = we listen
  logic [15:0] rx, next_rx;               // Sampled bits
  logic [6:0] bit_cnt, next_bit_cnt;      // Bits done in this frame
  logic [6:0] frame_len, next_frame_len;  // Bits in this frame
  logic mode_ls, next_mode_ls;            // Format latched at acceptance
  logic stop_pend, next_stop_pend;        // Stop after this byte
  logic scl_pull, next_scl_pull;          // Pull clock line low
  logic sda_pull, next_sda_pull;          // Pull data line low
  logic rsp_valid_r, next_rsp_valid;      // One-cycle answer strobe
  dfs_pkg::dfs_rsp_t rsp_r, next_rsp;     // Answer register
  logic [1:0] lines_s;                    // Synchronised clock, data
  logic sda_s;                            // Synchronised data line
  logic tick;                             // Quarter-bit enable pulse
  logic take;                             // Request accepted
  logic [5:0] reload;                     // Divider reload
  logic last_bit;                         // Final bit of the frame
  logic coll_now;                         // Collision seen this sample

  // Both lines cross into the core clock before anything reads them
  dfs_sync2 #(.WIDTH(2)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({serial_clock_line_in, serial_data_line_in}),
    .dout(lines_s)
  );
  assign sda_s = lines_s[0];

  // Open drain: level out is always low, the enable does the work
  assign serial_clock_line_out = 1'b0;
  assign serial_data_line_out = 1'b0;
  assign serial_clock_line_oe_n = ~scl_pull;
  assign serial_data_line_oe_n = ~sda_pull;

  // Requests only while idle and the PROM port is quiet
  assign cmd_ready = (state == dfs_pkg::DFS_IDLE) && prom_idle;
  assign take = cmd_valid && cmd_ready;
  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign bus_held = scl_pull || sda_pull;

  // Divider rate follows the latched format
  assign reload = mode_ls ? 6'(LS_QTR_CYC - 1) : 6'(HS_QTR_CYC - 1);
  assign tick = (state != dfs_pkg::DFS_IDLE) && (qcnt == 6'h00);
  assign last_bit = (bit_cnt == frame_len - 7'h01);
  // A released one read low means another driver won
  assign coll_now = mask[63] && tx[63] && !sda_s;

  // Next values of the whole sequencer
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_qcnt = qcnt;
    next_tx = tx;
    next_mask = mask;
    next_rx = rx;
    next_bit_cnt = bit_cnt;
    next_frame_len = frame_len;
    next_mode_ls = mode_ls;
    next_stop_pend = stop_pend;
    next_scl_pull = scl_pull;
    next_sda_pull = sda_pull;
    next_rsp_valid = 1'b0;
    next_rsp = rsp_r;
    // Divider runs only inside a transfer
    if (state != dfs_pkg::DFS_IDLE) begin
      next_qcnt = tick ? reload : qcnt - 6'h01;
    end
    case (state)
      dfs_pkg::DFS_IDLE: begin
        // Format chosen from strobe level at acceptance
        if (take) begin
          next_mode_ls = prom_load_strobe;
          next_stop_pend = cmd.stop;
          next_phase = 2'h0;
          next_bit_cnt = 7'h00;
          next_rx = 16'h0000;
          next_qcnt = 6'h00;
          if (prom_load_strobe) begin
            // Byte then acknowledge; the listener side of each bit flips
            next_frame_len = `DFS_LS_FRAME_BITS;
            next_tx = {cmd.wdata[7:0], !cmd.rd || cmd.stop, 55'h0};
            next_mask = cmd.rd ? {8'h00, 1'b1, 55'h0} : {8'hff, 1'b0, 55'h0};
            next_state = cmd.start ? dfs_pkg::DFS_START : dfs_pkg::DFS_BITS;
          end else begin
            // Preamble, start, opcode, ten address bits, turnaround, data
            next_frame_len = `DFS_HS_FRAME_BITS;
            if (cmd.rd) begin
              next_tx = {`DFS_MDIO_PRE, `DFS_MDIO_ST, `DFS_MDIO_OP_RD, cmd.phy, cmd.regad,
                         2'h3, 16'hffff};
              next_mask = {46'h3fffffffffff, 18'h00000};
            end else begin
              next_tx = {`DFS_MDIO_PRE, `DFS_MDIO_ST, `DFS_MDIO_OP_WR, cmd.phy, cmd.regad,
                         `DFS_MDIO_TA_WR, cmd.wdata};
              next_mask = 64'hffffffffffffffff;
            end
            next_state = dfs_pkg::DFS_BITS;
          end
        end
      end
      dfs_pkg::DFS_START: begin
        // Release data, release clock, data falls, clock falls
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            2'h0: next_sda_pull = 1'b0;
            2'h1: next_scl_pull = 1'b0;
            2'h2: next_sda_pull = 1'b1;
            default: begin
              next_scl_pull = 1'b1;
              next_state = dfs_pkg::DFS_BITS;
            end
          endcase
        end
      end
      dfs_pkg::DFS_BITS: begin
        // Set data while clock low, sample with clock high
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            2'h0: begin
              next_scl_pull = 1'b1;
              next_sda_pull = mask[63] && !tx[63];
            end
            2'h1: next_scl_pull = 1'b0;
            2'h2: begin
              next_rx = {rx[14:0], sda_s};
              if (coll_now) begin
                // Let go of both lines at once and report
                next_scl_pull = 1'b0;
                next_sda_pull = 1'b0;
                next_state = dfs_pkg::DFS_IDLE;
                next_rsp_valid = 1'b1;
                next_rsp = '{rdata: 16'h0000, nack: 1'b0, collision: 1'b1, mode_ls: mode_ls};
              end
            end
            default: begin
              next_scl_pull = 1'b1;
              next_tx = {tx[62:0], 1'b1};
              next_mask = {mask[62:0], 1'b0};
              next_bit_cnt = bit_cnt + 7'h01;
              if (last_bit) begin
                if (!mode_ls) begin
                  // Management frame ends with the bus free
                  next_scl_pull = 1'b0;
                  next_sda_pull = 1'b0;
                  next_state = dfs_pkg::DFS_IDLE;
                  next_rsp_valid = 1'b1;
                  next_rsp = '{rdata: rx, nack: 1'b0, collision: 1'b0, mode_ls: 1'b0};
                end else begin
                  // Low speed: rx bit 0 holds the acknowledge slot
                  next_rsp = '{rdata: {8'h00, rx[8:1]}, nack: rx[0], collision: 1'b0,
                               mode_ls: 1'b1};
                  if (stop_pend) begin
                    next_state = dfs_pkg::DFS_STOP;
                  end else begin
                    next_state = dfs_pkg::DFS_IDLE;
                    next_rsp_valid = 1'b1;
                  end
                end
              end
            end
          endcase
        end
      end
      dfs_pkg::DFS_STOP: begin
        // Data low, clock released, data released: bus free
        if (tick) begin
          next_phase = phase + 2'h1;
          case (phase)
            2'h0: next_sda_pull = 1'b1;
            2'h1: next_scl_pull = 1'b0;
            2'h2: next_sda_pull = 1'b0;
            default: begin
              next_state = dfs_pkg::DFS_IDLE;
              next_rsp_valid = 1'b1;
            end
          endcase
        end
      end
      default: next_state = dfs_pkg::DFS_IDLE;
    endcase
  end

  // Registers only; lines start released
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= dfs_pkg::DFS_IDLE;
      phase <= 2'h0;
      qcnt <= 6'h00;
      tx <= 64'h0;
      mask <= 64'h0;
      rx <= 16'h0000;
      bit_cnt <= 7'h00;
      frame_len <= 7'h00;
      mode_ls <= 1'b1;
      stop_pend <= 1'b0;
      scl_pull <= 1'b0;
      sda_pull <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      qcnt <= next_qcnt;
      tx <= next_tx;
      mask <= next_mask;
      rx <= next_rx;
      bit_cnt <= next_bit_cnt;
      frame_len <= next_frame_len;
      mode_ls <= next_mode_ls;
      stop_pend <= next_stop_pend;
      scl_pull <= next_scl_pull;
      sda_pull <= next_sda_pull;
      rsp_valid_r <= next_rsp_valid;
      rsp_r <= next_rsp;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_ls_frame_len: assert property (take && prom_load_strobe |=> frame_len == 7'h09)
    else $error("low-speed frame is not nine bits");
  a_ls_bit_rate: assert property (tick && mode_ls |=> qcnt == 6'(LS_QTR_CYC - 1))
    else $error("low-speed quarter bit too short");
  a_hs_frame_len: assert property (take && !prom_load_strobe |=> frame_len == 7'h40)
    else $error("management frame is not 64 bits");
  a_mode_latch: assert property (take |=> mode_ls == $past(prom_load_strobe))
    else $error("format not taken from load strobe");
  a_take_quiet: assert property (take |-> prom_idle && state == dfs_pkg::DFS_IDLE)
    else $error("request taken while PROM port busy");
  a_listen_release: assert property (state == dfs_pkg::DFS_BITS && phase == 2'h1 && !mask[63]
    |-> !sda_pull)
    else $error("data line driven during a receive bit");
  a_coll_abort: assert property (state == dfs_pkg::DFS_BITS && tick && phase == 2'h2 && coll_now
    |=> state == dfs_pkg::DFS_IDLE && serial_data_line_oe_n && serial_clock_line_oe_n
        && rsp_valid && rsp.collision)
    else $error("collision did not abort the transfer");
  a_hs_end_free: assert property (state == dfs_pkg::DFS_BITS && !mode_ls && tick && phase == 2'h3
    && last_bit |=> serial_clock_line_oe_n && serial_data_line_oe_n)
    else $error("bus not released after management frame");
  a_pins_low_only: assert property (!serial_data_line_oe_n || !serial_clock_line_oe_n
    |-> !serial_data_line_out && !serial_clock_line_out)
    else $error("line driven high");
endmodule // dfs_serial_master

// [verilog/dfs_regs.svh]
/*
  Constants of the dual format two-wire serial master: clock rate,
  bit-rate limits, quarter-bit counts and frame layouts.
  Assumes the core clock runs at the rate given here.
*/
`ifndef DFS_REGS_SVH
`define DFS_REGS_SVH

// Core clock in kHz
`define DFS_CLK_KHZ 50000
// Low-speed ceiling in kbps
`define DFS_LS_MAX_KBPS 400
// High-speed ceiling in kHz
`define DFS_HS_MAX_KHZ 25000
// Quarter-bit cycles, rounded up so the rate never exceeds the ceiling
`define DFS_LS_QTR_CYC ((`DFS_CLK_KHZ + 4 * `DFS_LS_MAX_KBPS - 1) / (4 * `DFS_LS_MAX_KBPS))
`define DFS_HS_QTR_CYC ((`DFS_CLK_KHZ + 4 * `DFS_HS_MAX_KHZ - 1) / (4 * `DFS_HS_MAX_KHZ))
// Fewest quarter cycles: the line levels reach the logic two cycles late
`define DFS_MIN_QTR_CYC 2
// Frame lengths in bits
`define DFS_LS_FRAME_BITS 7'h09
`define DFS_HS_FRAME_BITS 7'h40
// Management frame fields
`define DFS_MDIO_PRE 32'hffffffff
`define DFS_MDIO_ST 2'h1
`define DFS_MDIO_OP_RD 2'h2
`define DFS_MDIO_OP_WR 2'h1
`define DFS_MDIO_TA_WR 2'h2

`endif

// [verilog/dfs_pkg.sv]
/*
  Types of the dual format two-wire serial master.
  Assumes nothing of its surroundings.
*/
package dfs_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    DFS_IDLE  = 2'h0,
    DFS_START = 2'h1,
    DFS_BITS  = 2'h2,
    DFS_STOP  = 2'h3
  } dfs_state_t;

  // One request from the user side
  typedef struct packed {
    logic rd;           // Receive instead of transmit
    logic start;        // Low speed: start condition first
    logic stop;         // Low speed: stop after; on read also no-ack
    logic [4:0] phy;    // Management: port address
    logic [4:0] regad;  // Management: register address
    logic [15:0] wdata; // Write data; low speed uses bits 7:0
  } dfs_cmd_t;

  // One answer to the user side
  typedef struct packed {
    logic [15:0] rdata; // Read data; low speed in bits 7:0
    logic nack;         // Low speed write: slave did not acknowledge
    logic collision;    // Transfer abandoned on lost arbitration
    logic mode_ls;      // Format used: 1 low speed, 0 management
  } dfs_rsp_t;

endpackage

// [verilog/dfs_sync2.sv]
/*
  Two flip-flop synchroniser for pin levels.
  Assumes inputs are asynchronous levels; only the second stage is read.
*/
`timescale 1ns/10ps
module dfs_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta;

  // Width must be usable
  if (WIDTH < 1) begin : g_chk
    $error("dfs_sync2: WIDTH must be at least 1");
  end

  // Idle lines are high, so reset to ones
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta <= '1;
      dout <= '1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // dfs_sync2

// [verification/dfs_serial_slave_model.sv]
/*
  Behavioural slave on the two-wire bus: acks, returns read data, can
  force a collision by holding data low.
  Assumes the bench resolves both wires as wired-AND with pull-ups.
*/
`timescale 1ns/10ps
module dfs_serial_slave_model (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  input wire logic mode_ls,
  input wire logic rd,
  input wire logic [15:0] rword,
  input wire logic ack_off,
  input wire logic clash,
  input wire logic arm,
  input wire logic first_slot,
  output logic pull_n,
  output logic [63:0] got,
  output int n_start,
  output int n_stop
);
  int slot = 64; // Current bit slot; 64 means quiet
  logic pull; // Slave pulls data low
  logic scl_q = 1'b1; // Wire levels one core cycle back
  logic sda_q = 1'b1;
  initial got = 64'h0;
  initial n_start = 0;
  initial n_stop = 0;
  // Re-arm before each request; a byte without start opens slot 0 at once
  always @(posedge arm) slot = first_slot ? 0 : -1;
  // Conditions seen on the core clock, so edges in one step never look like one
  always @(posedge clock) begin
    if (scl_q && scl && sda_q && !sda) begin
      n_start++;
      slot = -1;
    end
    if (scl_q && scl && !sda_q && sda) n_stop++;
    scl_q <= scl;
    sda_q <= sda;
  end
  // Slot advances on falling clock
  always @(negedge scl) if (slot < 64) slot++;
  // Bits stored by slot, so extra rising edges at frame ends do no harm
  always @(posedge scl) begin
    if (slot >= 0 && slot < 64) got[63 - slot] <= sda;
    if (!mode_ls && slot == 63) slot = 64;
  end
  // Pulls inside its own slots as they ask, and outside them while clash is set; elsewhere the pull-up wins
  always_comb begin
    pull = clash;
    if (mode_ls && rd && slot >= 0 && slot < 8) pull = !rword[7 - slot];
    if (mode_ls && !rd && slot == 8) pull = !ack_off;
    if (!mode_ls && rd && slot >= 47 && slot < 64) begin
      pull = (slot == 47) || !rword[63 - slot];
    end
  end
  assign pull_n = !pull;
endmodule // dfs_serial_slave_model

// [verification/dual_format_two_wire_serial_tb_top.sv]
/*
  Bench for the two-wire master: corner and random requests in both
  formats against the slave model, checked at the command port and wire.
  Assumes a 50 MHz core clock; quarter-bit count shortened to 2.
*/
`timescale 1ns/10ps
module dual_format_two_wire_serial_tb_top;
  localparam int Q = 2; // Quarter-bit cycles: 160 ns low-speed bit
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic prom_load_strobe = 1'b1;
  logic prom_idle = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready, rsp_valid, bus_held;
  dfs_pkg::dfs_cmd_t cmd = '0;
  dfs_pkg::dfs_rsp_t rsp;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, s_pull_n;
  logic ls = 1'b1, rd = 1'b0, ack_off = 1'b0, clash = 1'b0;
  logic arm = 1'b0, first_slot = 1'b0, held = 1'b0;
  logic [15:0] rword = 16'h0;
  logic [63:0] got;
  int n_start, n_stop;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 32'h56db;
  wire scl = scl_oe_n; // Only the master drives the clock
  wire sda = sda_oe_n & s_pull_n; // Wired-AND with pull-up

  always #10 clock = ~clock;

  dfs_serial_master #(.LS_QTR_CYC(Q), .HS_QTR_CYC(Q)) dut_u (
    .clock(clock), .resetn(resetn), .prom_load_strobe(prom_load_strobe),
    .prom_idle(prom_idle), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .bus_held(bus_held),
    .serial_clock_line_in(scl), .serial_clock_line_out(scl_out),
    .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_in(sda),
    .serial_data_line_out(sda_out), .serial_data_line_oe_n(sda_oe_n));

  dfs_serial_slave_model slave_u (
    .clock(clock), .scl(scl), .sda(sda), .mode_ls(ls), .rd(rd), .rword(rword),
    .ack_off(ack_off), .clash(clash), .arm(arm), .first_slot(first_slot),
    .pull_n(s_pull_n), .got(got), .n_start(n_start), .n_stop(n_stop));

  // Compare of values
  task automatic chk_vec(input logic [63:0] g, input logic [63:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  // Compare of counts
  task automatic chk_num(input int g, input int e, input string what);
    n_compared++;
    if (g != e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycles from take to answer
  function automatic int exp_lat(input logic l, input dfs_pkg::dfs_cmd_t c);
    if (!l) return 1 + 255 * Q;
    return 1 + 35 * Q + (c.start ? 4 * Q : 0) + (c.stop ? 4 * Q : 0);
  endfunction
  // Whole management frame as it should appear on the data line
  function automatic logic [63:0] exp_frame(input dfs_pkg::dfs_cmd_t c, input logic [15:0] w);
    return {32'hffffffff, 2'h1, c.rd ? 2'h2 : 2'h1, c.phy, c.regad, 2'h2, c.rd ? w : c.wdata};
  endfunction

  // One request, from arming the slave to the checks on the answer
  task automatic run(input logic l, input dfs_pkg::dfs_cmd_t c, input logic x);
    int n;
    int s0;
    int p0;
    logic a;
    @(posedge clock);
    #1;
    s0 = n_start;
    p0 = n_stop;
    ls = l;
    rd = c.rd;
    clash = x;
    first_slot = l && !c.start;
    prom_load_strobe = l;
    cmd = c;
    arm = 1'b1;
    cmd_valid = 1'b1;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clock);
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    arm = 1'b0;
    prom_load_strobe = 1'($random(seed)); // Late change must not matter
    @(negedge clock);
    chk_vec(cmd_ready, 1'b0, "ready during transfer");
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    a = c.rd ? c.stop : ack_off;
    if (x) begin
      chk_vec(rsp.collision, 1'b1, "collision flag");
      chk_vec(n < exp_lat(l, c), 1'b1, "early end");
      @(negedge clock);
      chk_vec({bus_held, scl_oe_n, sda_oe_n}, 3'h3, "released after loss");
      clash = 1'b0;
      held = 1'b0;
      return;
    end
    chk_num(n, exp_lat(l, c), "latency");
    chk_vec({rsp.collision, rsp.mode_ls}, {1'b0, l}, "format");
    if (l) begin
      chk_vec(got[63:55], {c.rd ? rword[7:0] : c.wdata[7:0], a}, "byte on wire");
      chk_vec(rsp.nack, a, "ack slot");
      if (c.rd) chk_vec(rsp.rdata[7:0], rword[7:0], "read byte");
      chk_num(n_start - s0, c.start, "starts");
      chk_num(n_stop - p0, c.stop, "stops");
    end else begin
      chk_vec(got, exp_frame(c, rword), "frame");
      if (c.rd) chk_vec(rsp.rdata, rword, "read word");
    end
    held = l && !c.stop;
    chk_vec({bus_held, scl_oe_n, held | sda_oe_n}, {held, !held, 1'b1}, "bus state");
    chk_vec({scl_out, sda_out}, 2'h0, "open drain");
  endtask

  // Main sequence: reset, refusal, collisions, byte chain, random mix
  initial begin
    dfs_pkg::dfs_cmd_t c;
    logic l;
    repeat (10) @(posedge clock);
    chk_vec({scl_oe_n, sda_oe_n, rsp_valid, bus_held}, 4'hc, "reset state");
    #1;
    resetn = 1'b1;
    prom_idle = 1'b0;
    cmd_valid = 1'b1;
    repeat (3) @(negedge clock);
    chk_vec({cmd_ready, bus_held, scl_oe_n}, 3'h1, "held off while PROM busy");
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    prom_idle = 1'b1;
    run(1'b1, {3'h2, 10'h0, 16'h00ff}, 1'b1);
    run(1'b0, {3'h0, 10'h3ff, 16'hffff}, 1'b1);
    ack_off = 1'b1;
    run(1'b1, {3'h2, 10'h0, 16'h00a5}, 1'b0);
    ack_off = 1'b0;
    rword = 16'h003c;
    run(1'b1, {3'h4, 10'h0, 16'h0000}, 1'b0);
    run(1'b1, {3'h7, 10'h0, 16'h0000}, 1'b0);
    // Random mix; a held bus keeps the byte format until a stop
    for (int i = 0; i < 24; i++) begin
      c = 29'($random(seed));
      rword = 16'($random(seed));
      ack_off = 1'($random(seed));
      l = held | 1'($random(seed));
      if (!held) c.start = 1'b1;
      run(l, c, 1'b0);
    end
    end_of_test();
  end

  // Watchdog: about 30 requests of at most 600 cycles need well under 1 ms
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
endmodule // dual_format_two_wire_serial_tb_top
